// [shared/rlc_pkg.sv]
// shared constants and types for the ramp limit and dwell control block
`default_nettype none
package rlc_pkg;
  localparam int RLC_DW = 32;                 // ramp output width
  localparam int RLC_LIM_W = 64;              // limit pair width
  localparam int RLC_UPPER_LSB = 32;          // upper limit sits in bits 63:32
  localparam int RLC_LOWER_LSB = 0;           // lower limit sits in bits 31:0
  localparam int RLC_DIV = 16;                // dds clock = system clock / 16
  localparam int RLC_DONE_PULSE = 2;          // done pulse length in dds cycles
  localparam logic [1:0] RLC_ND_DWELL = 2'h0; // both no-dwell bits clear
  localparam logic [1:0] RLC_ND_LOW = 2'h1;   // no-dwell low
  localparam logic [1:0] RLC_ND_HIGH = 2'h2;  // no-dwell high
  localparam logic [1:0] RLC_ND_CONT = 2'h3;  // continuous ramping
  localparam logic [1:0] RLC_DEST_FREQ = 2'h0;
  localparam logic [1:0] RLC_DEST_PHASE = 2'h1;
  localparam int RLC_PHASE_W = 16;
  localparam int RLC_AMP_W = 12;
  localparam logic [63:0] RLC_LIM_RST = 64'hffffffff00000000; // upper all ones, lower zero

  typedef enum logic [3:0] {
    RLC_ST_IDLE = 4'h1,   // disabled or waiting for an edge
    RLC_ST_UP = 4'h2,     // positive slope
    RLC_ST_DOWN = 4'h4,   // negative slope
    RLC_ST_AT_LIM = 4'h8  // parked at a limit
  } rlc_state_t;
endpackage
`default_nettype wire

// [shared/rlc_step_if.sv]
// carrier between the sequencer and the limit stage
`default_nettype none
interface rlc_step_if;
  logic [31:0] acc;     // current accumulator value
  logic [31:0] step;    // step magnitude this tick
  logic up;             // step direction
  logic [31:0] upper;   // upper limit
  logic [31:0] lower;   // lower limit
  logic [31:0] nxt;     // clamped next value
  logic hit_upper;      // next value sits at upper limit
  logic hit_lower;      // next value sits at lower limit
  modport seq (output acc, step, up, upper, lower, input nxt, hit_upper, hit_lower);
  modport lim (input acc, step, up, upper, lower, output nxt, hit_upper, hit_lower);
endinterface
`default_nettype wire

// [core/rlc_limit.sv]
// limit stage in the accumulator feedback path
`default_nettype none
module rlc_limit (
  rlc_step_if.lim s // step request and clamped answer
);
  import rlc_pkg::*;
  // sum widened by one bit so wrap past either end is seen, not folded
  wire logic [32:0] sum_up = {1'b0, s.acc} + {1'b0, s.step};
  wire logic [32:0] sum_dn = {1'b0, s.acc} - {1'b0, s.step};
  wire logic over = sum_up[32] || (sum_up[31:0] >= s.upper);
  wire logic under = sum_dn[32] || (sum_dn[31:0] <= s.lower);
  // saturate to the active limit so the clamped value feeds back (see RQ21) (see RQ1)
  assign s.nxt = s.up ? (over ? s.upper : sum_up[31:0]) : (under ? s.lower : sum_dn[31:0]);
  assign s.hit_upper = s.up && over;
  assign s.hit_lower = !s.up && under;
endmodule
`default_nettype wire

// [core/rlc_tick.sv]
// dds clock tick and slope interval timer
`default_nettype none
module rlc_tick #(
  parameter int DIV = 16 // system clocks per dds clock
) (
  input wire logic i_clk,          // system clock
  input wire logic i_nrst,         // async reset, active low
  input wire logic i_run,          // enable; low stops the divider
  input wire logic i_reload,       // restart interval timer
  input wire logic [15:0] i_rate,  // step interval in dds cycles
  output logic o_dds_tick,         // one pulse per dds clock
  output logic o_step              // interval expired on this dds tick
);
  logic [$clog2(DIV)-1:0] div_ff;
  logic [15:0] tmr_ff;
  assign o_dds_tick = i_run && (div_ff == ($clog2(DIV))'(DIV - 1));
  assign o_step = o_dds_tick && (tmr_ff <= 16'h0001);
  // idle divider while disabled to save switching power
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_ff <= '0;
      tmr_ff <= 16'h0000;
    end else begin
      div_ff <= i_run ? div_ff + 1'b1 : '0;
      if (i_reload || !i_run) begin
        tmr_ff <= i_rate;
      end else if (o_step) begin
        tmr_ff <= i_rate;
      end else if (o_dds_tick) begin
        tmr_ff <= tmr_ff - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// [core/rlc_ramp_ctrl.sv]
// ramp generator limit, clear, hold and dwell control
// Summary of operation
// (RQ1) output stays between upper and lower limit from one 64-bit register
// (RQ2) software loads an upper limit strictly above the lower limit
// (RQ3) phase sweeps use the low 16 limit bits, high 16 zero
// (RQ4) amplitude sweeps use the low 12 limit bits, high 20 zero
// (RQ5) accumulator clear presets output to the lower limit
// (RQ6) enable acts at update; direction high starts rising, else lower limit
// (RQ7) dwell: stay at upper until direction low or upper limit raised
// (RQ8) dwell: stay at lower until direction high or lower limit lowered
// (RQ9) hold pin freezes the accumulator; release continues the slope
// (RQ10) registered clear bit holds output at lower limit; removal restarts slope
// (RQ11) registered autoclear resets the accumulator for one dds cycle
// (RQ12) no-dwell high: reaching upper jumps to lower and halts
// (RQ13) no-dwell low: reaching lower jumps to upper and halts
// (RQ14) both no-dwell bits: oscillate between limits on its own
// (RQ15) dwell operation: done output static high at the end limit
// (RQ16) continuous mode: done pulses two dds cycles; gated by enable bit
// (RQ17) no-dwell high: rising direction edge starts; others ignored until upper
// (RQ18) no-dwell low: falling direction edge starts; others ignored until lower
// (RQ19) ramp disabled ignores other controls and stops internal clocking
// (RQ20) destination field routes bits 31:0, 15:0 or 11:0 to parameter
// (RQ21) next value is clamped to the active limit before feedback
`default_nettype none
module rlc_ramp_ctrl #(
  parameter int DIV = rlc_pkg::RLC_DIV // system clocks per dds clock
) (
  input wire logic I_SYS_CLK,                          // system clock
  input wire logic I_NRST,                             // async reset, active low
  input wire logic I_IO_UPDATE,                        // one-cycle update strobe
  input wire logic I_LIMIT_WE,                         // write limit pair
  input wire logic [rlc_pkg::RLC_LIM_W-1:0] I_LIMIT_D, // limit pair data
  input wire logic I_RAMP_EN,                          // ramp enable bit, staged
  input wire logic I_CLR_ACC,                          // clear accumulator bit, staged
  input wire logic I_AUTOCLR,                          // autoclear bit, staged
  input wire logic [1:0] I_NO_DWELL,                   // no-dwell high,low bits, staged
  input wire logic I_DONE_OE,                          // done output enable bit, staged
  input wire logic [1:0] I_DEST,                       // destination field, staged
  input wire logic [31:0] I_STEP_P,                    // rising step size
  input wire logic [31:0] I_STEP_N,                    // falling step size
  input wire logic [15:0] I_RATE_P,                    // rising interval, dds cycles
  input wire logic [15:0] I_RATE_N,                    // falling interval, dds cycles
  input wire logic I_RAMP_DIRECTION_PIN,               // direction from controller
  input wire logic I_RAMP_HOLD_PIN,                    // hold from controller
  output logic [rlc_pkg::RLC_LIM_W-1:0] O_LIMIT_Q,     // limit pair readback
  output logic [31:0] O_RAMP_OUT,                      // ramp output bus
  output logic [31:0] O_FREQ,                          // frequency parameter
  output logic [15:0] O_PHASE,                         // phase parameter
  output logic [11:0] O_AMP,                           // amplitude parameter
  output logic [1:0] O_DEST_SEL,                       // active destination
  output logic O_RAMP_DONE_OUTPUT                      // sweep done indicator
);
  import rlc_pkg::*;
  logic [63:0] lim_ff;
  logic en_ff, clr_ff, oe_ff;
  logic [1:0] nd_ff, dest_ff;
  logic [31:0] acc_ff;
  rlc_state_t st_ff, nxt_st;
  logic slope_up_ff, dir_ff, done_ff, autoclr_ff;
  logic [1:0] pulse_ff;
  logic [31:0] nxt_acc, freq_ff;
  logic [15:0] phase_ff;
  logic [11:0] amp_ff;
  logic nxt_slope_up, nxt_done, nxt_pulse;

  rlc_step_if stp();

  wire logic [31:0] upper = lim_ff[RLC_UPPER_LSB +: RLC_DW];
  wire logic [31:0] lower = lim_ff[RLC_LOWER_LSB +: RLC_DW];
  wire logic [31:0] new_upper = I_LIMIT_D[RLC_UPPER_LSB +: RLC_DW];
  wire logic [31:0] new_lower = I_LIMIT_D[RLC_LOWER_LSB +: RLC_DW];
  // limit raise or lower while parked resumes the previous slope
  wire logic upper_raised = I_LIMIT_WE && (new_upper > upper);
  wire logic lower_dropped = I_LIMIT_WE && (new_lower < lower);
  wire logic dir_rise = I_RAMP_DIRECTION_PIN && !dir_ff;
  wire logic dir_fall = !I_RAMP_DIRECTION_PIN && dir_ff;
  wire logic enable_edge = I_IO_UPDATE && I_RAMP_EN && !en_ff;
  wire logic in_clear = clr_ff || autoclr_ff;
  wire logic dds_tick, step_now;
  wire logic nd_high = (nd_ff == RLC_ND_HIGH);
  wire logic nd_low = (nd_ff == RLC_ND_LOW);
  wire logic nd_cont = (nd_ff == RLC_ND_CONT);
  wire logic nd_dwell = (nd_ff == RLC_ND_DWELL);

  // interval timer reloads on enable edge, direction pin edge and each step
  rlc_tick #(.DIV(DIV)) u_tick (
    .i_clk(I_SYS_CLK),
    .i_nrst(I_NRST),
    .i_run(en_ff), // see RQ19
    .i_reload(enable_edge || dir_rise || dir_fall),
    .i_rate(slope_up_ff ? I_RATE_P : I_RATE_N),
    .o_dds_tick(dds_tick),
    .o_step(step_now)
  );

  assign stp.acc = acc_ff;
  assign stp.step = slope_up_ff ? I_STEP_P : I_STEP_N;
  assign stp.up = slope_up_ff;
  assign stp.upper = upper;
  assign stp.lower = lower;
  rlc_limit u_limit (
    .s(stp)
  );

  // accumulator may advance only when moving, not held, not cleared
  wire logic moving = (st_ff == RLC_ST_UP) || (st_ff == RLC_ST_DOWN);
  wire logic advance = step_now && moving && !I_RAMP_HOLD_PIN && !in_clear; // see RQ9

  // sequencer; in-flight no-dwell high and low sweeps ignore direction until their limit
  always_comb begin
    nxt_st = st_ff;
    nxt_acc = acc_ff;
    nxt_slope_up = slope_up_ff;
    nxt_done = done_ff;
    nxt_pulse = 1'b0;
    case (st_ff)
      RLC_ST_IDLE: begin
        if (nd_high && dir_rise) begin // see RQ17
          nxt_st = RLC_ST_UP;
          nxt_slope_up = 1'b1;
          nxt_done = 1'b0;
        end else if (nd_low && dir_fall) begin // see RQ18
          nxt_st = RLC_ST_DOWN;
          nxt_slope_up = 1'b0;
          nxt_done = 1'b0;
        end else if (nd_dwell || nd_cont) begin
          nxt_st = I_RAMP_DIRECTION_PIN ? RLC_ST_UP : RLC_ST_DOWN;
          nxt_slope_up = I_RAMP_DIRECTION_PIN;
        end
      end
      RLC_ST_UP, RLC_ST_DOWN: begin
        if (nd_dwell && (I_RAMP_DIRECTION_PIN != slope_up_ff)) begin
          nxt_slope_up = I_RAMP_DIRECTION_PIN;
          nxt_st = I_RAMP_DIRECTION_PIN ? RLC_ST_UP : RLC_ST_DOWN;
        end else if (nd_cont && (dir_rise || dir_fall)) begin
          nxt_slope_up = dir_rise;
          nxt_st = dir_rise ? RLC_ST_UP : RLC_ST_DOWN;
        end else if (advance) begin
          nxt_acc = stp.nxt; // see RQ21
          if (stp.hit_upper || stp.hit_lower) begin
            nxt_done = 1'b1;
            if (nd_cont) begin // see RQ14
              nxt_slope_up = !slope_up_ff;
              nxt_st = slope_up_ff ? RLC_ST_DOWN : RLC_ST_UP;
              nxt_pulse = 1'b1;
            end else if (nd_high) begin // see RQ12
              nxt_acc = lower;
              nxt_st = RLC_ST_IDLE;
            end else if (nd_low) begin // see RQ13
              nxt_acc = upper;
              nxt_st = RLC_ST_IDLE;
            end else begin
              nxt_st = RLC_ST_AT_LIM; // see RQ15
            end
          end else begin
            nxt_done = 1'b0;
          end
        end
      end
      RLC_ST_AT_LIM: begin
        // park until direction reverses or limit moves outward
        if (slope_up_ff && (!I_RAMP_DIRECTION_PIN || upper_raised)) begin // see RQ7
          nxt_slope_up = I_RAMP_DIRECTION_PIN;
          nxt_st = I_RAMP_DIRECTION_PIN ? RLC_ST_UP : RLC_ST_DOWN;
          nxt_done = 1'b0;
        end else if (!slope_up_ff && (I_RAMP_DIRECTION_PIN || lower_dropped)) begin // see RQ8
          nxt_slope_up = I_RAMP_DIRECTION_PIN;
          nxt_st = I_RAMP_DIRECTION_PIN ? RLC_ST_UP : RLC_ST_DOWN;
          nxt_done = 1'b0;
        end
      end
      default: begin
        nxt_st = RLC_ST_IDLE;
      end
    endcase
    // clear presets the accumulator to the lower limit each cycle it is held
    // a parked ramp leaves its limit on clear, so the slope restarts once the clear drops
    if (in_clear) begin // see RQ5 see RQ10 see RQ11
      nxt_acc = lower;
      if (st_ff == RLC_ST_AT_LIM) begin
        nxt_st = slope_up_ff ? RLC_ST_UP : RLC_ST_DOWN;
        nxt_done = 1'b0;
      end
    end
  end

  // staged control bits take effect only on io update
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      en_ff <= 1'b0;
      clr_ff <= 1'b0;
      oe_ff <= 1'b0;
      nd_ff <= RLC_ND_DWELL;
      dest_ff <= RLC_DEST_FREQ;
    end else if (I_IO_UPDATE) begin
      en_ff <= I_RAMP_EN; // see RQ6
      clr_ff <= I_CLR_ACC; // see RQ10
      oe_ff <= I_DONE_OE;
      nd_ff <= I_NO_DWELL;
      dest_ff <= I_DEST;
    end
  end

  // autoclear holds the accumulator in reset for one dds clock only
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      autoclr_ff <= 1'b0;
    end else if (I_IO_UPDATE && I_AUTOCLR) begin
      autoclr_ff <= 1'b1; // see RQ11
    end else if (dds_tick || !en_ff) begin
      autoclr_ff <= 1'b0;
    end
  end

  // limit register written directly, no io update needed
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      lim_ff <= RLC_LIM_RST;
    end else if (I_LIMIT_WE) begin
      lim_ff <= I_LIMIT_D; // see RQ1
    end
  end

  // ramp core; disabled ramp ignores pins and parks idle at the lower limit
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      st_ff <= RLC_ST_IDLE;
      acc_ff <= 32'h00000000;
      slope_up_ff <= 1'b0;
      done_ff <= 1'b0;
      dir_ff <= 1'b0;
    end else if (!en_ff) begin
      st_ff <= RLC_ST_IDLE; // see RQ19
      acc_ff <= lower; // see RQ6
      slope_up_ff <= 1'b0;
      done_ff <= 1'b0;
      dir_ff <= I_RAMP_DIRECTION_PIN;
    end else begin
      st_ff <= nxt_st;
      acc_ff <= nxt_acc;
      slope_up_ff <= nxt_slope_up;
      done_ff <= nxt_done;
      dir_ff <= I_RAMP_DIRECTION_PIN;
    end
  end

  // two dds cycle pulse counter for continuous mode
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pulse_ff <= 2'h0;
    end else if (nxt_pulse && en_ff) begin
      pulse_ff <= 2'(RLC_DONE_PULSE); // see RQ16
    end else if (dds_tick && pulse_ff != 2'h0) begin
      pulse_ff <= pulse_ff - 2'h1;
    end
  end

  // destination routing; unused upper bits dropped
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      freq_ff <= 32'h00000000;
      phase_ff <= 16'h0000;
      amp_ff <= 12'h000;
    end else if (en_ff) begin
      if (dest_ff == RLC_DEST_FREQ) begin // see RQ20
        freq_ff <= acc_ff;
      end else if (dest_ff == RLC_DEST_PHASE) begin
        phase_ff <= acc_ff[RLC_PHASE_W-1:0];
      end else begin
        amp_ff <= acc_ff[RLC_AMP_W-1:0];
      end
    end
  end

  assign O_LIMIT_Q = lim_ff;
  assign O_RAMP_OUT = acc_ff;
  assign O_FREQ = freq_ff;
  assign O_PHASE = phase_ff;
  assign O_AMP = amp_ff;
  assign O_DEST_SEL = dest_ff;
  // done gated by output enable; static in dwell modes, pulsed in continuous
  assign O_RAMP_DONE_OUTPUT = en_ff && oe_ff && (nd_cont ? (pulse_ff != 2'h0) : done_ff); // see RQ15 see RQ16
endmodule
`default_nettype wire

// [dv/rlc_ramp_ctrl_properties.sv]
// concurrent checks on the ramp limit and dwell control ports
`default_nettype none
module rlc_ramp_props
  import rlc_pkg::*;
#(
  parameter int DIV = 16 // system clocks per dds clock
) (
  input wire logic I_SYS_CLK, // system clock
  input wire logic I_NRST, // async reset, active low
  input wire logic I_IO_UPDATE, // update strobe
  input wire logic I_LIMIT_WE, // limit write
  input wire logic [63:0] I_LIMIT_D, // limit data
  input wire logic I_RAMP_EN, // staged enable
  input wire logic I_CLR_ACC, // staged clear
  input wire logic I_AUTOCLR, // staged autoclear
  input wire logic [1:0] I_NO_DWELL, // staged no-dwell
  input wire logic I_DONE_OE, // staged done enable
  input wire logic [1:0] I_DEST, // staged destination
  input wire logic I_RAMP_DIRECTION_PIN, // direction pin
  input wire logic I_RAMP_HOLD_PIN, // hold pin
  input wire logic [63:0] O_LIMIT_Q, // limit readback
  input wire logic [31:0] O_RAMP_OUT, // ramp output
  input wire logic [1:0] O_DEST_SEL, // active destination
  input wire logic O_RAMP_DONE_OUTPUT // done indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] m_ff; // {enable, clear, done enable, no-dwell}
  wire logic [31:0] up_w = O_LIMIT_Q[63:32];
  wire logic [31:0] lo_w = O_LIMIT_Q[31:0];
  // mirror of the control bits, taken only at an update like the block does
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      m_ff <= 5'h0;
    end else if (I_IO_UPDATE) begin
      m_ff <= {I_RAMP_EN, I_CLR_ACC, I_DONE_OE, I_NO_DWELL};
    end
  end
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_NRST);
  // limit changes are excluded: a narrowed limit needs a step to pull the output in
  a_out_bounded: assert property (m_ff[4] && $past(m_ff[4]) && $stable(O_LIMIT_Q) |->
    O_RAMP_OUT <= up_w && O_RAMP_OUT >= lo_w) else $error("ramp output outside limits");
  a_limit_write: assert property (I_LIMIT_WE |=> O_LIMIT_Q == $past(I_LIMIT_D))
    else $error("limit pair not written");
  a_clear_lower: assert property (m_ff[3] && $past(m_ff[3]) && m_ff[4] && $stable(O_LIMIT_Q) |->
    O_RAMP_OUT == lo_w) else $error("cleared ramp not at lower limit");
  a_off_lower: assert property (!m_ff[4] && !$past(m_ff[4]) && !$past(I_LIMIT_WE) && $stable(O_LIMIT_Q) |->
    O_RAMP_OUT == lo_w) else $error("disabled ramp not at lower limit");
  a_hold_freeze: assert property (I_RAMP_HOLD_PIN && $past(I_RAMP_HOLD_PIN) && !I_IO_UPDATE &&
    !$past(I_IO_UPDATE) && !I_LIMIT_WE && !$past(I_LIMIT_WE) |=> $stable(O_RAMP_OUT)) else $error("held ramp moved");
  a_dest_taken: assert property (I_IO_UPDATE |=> O_DEST_SEL == $past(I_DEST))
    else $error("destination not registered");
  a_done_gated: assert property (!m_ff[2] |-> !O_RAMP_DONE_OUTPUT)
    else $error("done high while its enable is off");
  a_dwell_done: assert property (m_ff[4] && m_ff[2] && !m_ff[3] && m_ff[1:0] == RLC_ND_DWELL &&
    I_RAMP_DIRECTION_PIN && $past(I_RAMP_DIRECTION_PIN) && O_RAMP_OUT == up_w && $past(O_RAMP_OUT) == up_w &&
    $stable(O_LIMIT_Q) |-> O_RAMP_DONE_OUTPUT) else $error("done low while dwelling at upper limit");
  a_cont_pulse: assert property (m_ff[1:0] == RLC_ND_CONT && $rose(O_RAMP_DONE_OUTPUT) |->
    O_RAMP_DONE_OUTPUT[*3] ##[1:8] !O_RAMP_DONE_OUTPUT) else $error("continuous done pulse length wrong");
  a_autoclr: assert property (I_IO_UPDATE && I_AUTOCLR && I_RAMP_EN && m_ff[4] && !I_LIMIT_WE |->
    ##[1:6] O_RAMP_OUT == lo_w) else $error("autoclear did not reach lower limit");
endmodule
bind rlc_ramp_ctrl rlc_ramp_props #(.DIV(DIV)) u_props (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST),
  .I_IO_UPDATE(I_IO_UPDATE), .I_LIMIT_WE(I_LIMIT_WE), .I_LIMIT_D(I_LIMIT_D), .I_RAMP_EN(I_RAMP_EN),
  .I_CLR_ACC(I_CLR_ACC), .I_AUTOCLR(I_AUTOCLR), .I_NO_DWELL(I_NO_DWELL), .I_DONE_OE(I_DONE_OE), .I_DEST(I_DEST),
  .I_RAMP_DIRECTION_PIN(I_RAMP_DIRECTION_PIN), .I_RAMP_HOLD_PIN(I_RAMP_HOLD_PIN), .O_LIMIT_Q(O_LIMIT_Q),
  .O_RAMP_OUT(O_RAMP_OUT), .O_DEST_SEL(O_DEST_SEL), .O_RAMP_DONE_OUTPUT(O_RAMP_DONE_OUTPUT));
`default_nettype wire

// [dv/rlc_ctrl_model.sv]
// model of the outside controller that drives the direction and hold pins
`default_nettype none
module rlc_ctrl_model (
  input wire logic i_clk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_dir_cmd, // wanted direction level
  input wire logic i_hold_cmd, // wanted hold level
  output logic o_dir, // ramp direction pin
  output logic o_hold // ramp hold pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins move just after an edge, so the block always samples a settled level
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dir <= 1'b0;
      o_hold <= 1'b0;
    end else begin
      o_dir <= i_dir_cmd;
      o_hold <= i_hold_cmd;
    end
  end
endmodule
`default_nettype wire

// [dv/tb_rlc_ramp_ctrl.sv]
// bench for the ramp limit and dwell control block
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_rlc_ramp_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import rlc_pkg::*;
  int num_errors = 0;
  int check_count = 0;
  int edges;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic upd = 1'b0;
  logic we = 1'b0;
  logic dcmd = 1'b0;
  logic hcmd = 1'b0;
  logic pd, dir, hold, done, en, clr, ac, oe;
  logic [1:0] nd, dest, dsel;
  logic [7:0] ctl = 8'h0;
  logic [63:0] lim_d = 64'h0;
  logic [63:0] lim_q;
  logic [31:0] sp = 32'h20;
  logic [31:0] sn = 32'h30;
  logic [31:0] out, freq, mn, mx;
  logic [15:0] rp = 16'h1;
  logic [15:0] rn = 16'h1;
  logic [15:0] phase;
  logic [11:0] amp;
  // ctl = {enable, clear, autoclear, no-dwell, done enable, destination}
  assign {en, clr, ac, nd, oe, dest} = ctl;
  rlc_ramp_ctrl #(.DIV(2)) u_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_IO_UPDATE(upd), .I_LIMIT_WE(we),
    .I_LIMIT_D(lim_d), .I_RAMP_EN(en), .I_CLR_ACC(clr), .I_AUTOCLR(ac), .I_NO_DWELL(nd), .I_DONE_OE(oe),
    .I_DEST(dest), .I_STEP_P(sp), .I_STEP_N(sn), .I_RATE_P(rp), .I_RATE_N(rn), .I_RAMP_DIRECTION_PIN(dir),
    .I_RAMP_HOLD_PIN(hold), .O_LIMIT_Q(lim_q), .O_RAMP_OUT(out), .O_FREQ(freq), .O_PHASE(phase), .O_AMP(amp),
    .O_DEST_SEL(dsel), .O_RAMP_DONE_OUTPUT(done));
  rlc_ctrl_model u_ctrl (.i_clk(clk), .i_nrst(nrst), .i_dir_cmd(dcmd), .i_hold_cmd(hcmd), .o_dir(dir),
    .o_hold(hold));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // staged bits only act at the edge where the update strobe is high
  task automatic send(input logic [7:0] c);
    @(posedge clk);
    ctl <= c;
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
  endtask
  task automatic pins(input logic d, input logic h);
    @(posedge clk);
    dcmd <= d;
    hcmd <= h;
  endtask
  task automatic setlim(input logic [31:0] u, input logic [31:0] l);
    @(posedge clk);
    lim_d <= {u, l};
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(negedge clk);
    `CHK("limit pair", {u, l}, lim_q)
  endtask
  task automatic wait_out(input logic [31:0] v);
    for (int i = 0; i < 300 && out !== v; i++) @(negedge clk);
    `CHK("ramp output", v, out)
  endtask
  // track extremes and done pulses over a window
  task automatic watch(input int n);
    mn = '1;
    mx = '0;
    edges = 0;
    pd = done;
    repeat (n) begin
      @(negedge clk);
      if (out < mn) mn = out;
      if (out > mx) mx = out;
      if (done === 1'b1 && pd !== 1'b1) edges++;
      pd = done;
    end
  endtask
  task automatic t_dwell;
    @(negedge clk);
    `CHK("limit reset", RLC_LIM_RST, lim_q)
    setlim(32'h100, 32'h10);
    cyc(3);
    @(posedge clk);
    ctl <= 8'h80;
    pins(1'b1, 1'b0);
    cyc(6);
    @(negedge clk);
    `CHK("enable before update", 32'h10, out)
    send(8'h80);
    wait_out(32'h100);
    cyc(10);
    @(negedge clk);
    `CHK("dwell upper", 32'h100, out)
    `CHK("done off", 1'b0, done)
    send(8'h84);
    @(negedge clk);
    `CHK("done static", 1'b1, done)
    // limits fit 12 bits with zero upper bits so they also serve phase and amplitude
    setlim(32'h140, 32'h10);
    wait_out(32'h140);
    pins(1'b0, 1'b0);
    wait_out(32'h10);
    setlim(32'h140, 32'h4);
    wait_out(32'h4);
    $display("test dwell finished");
  endtask
  task automatic t_hold;
    pins(1'b1, 1'b0);
    cyc(6);
    pins(1'b1, 1'b1);
    watch(3);
    watch(12);
    `CHK("hold frozen", mn, mx)
    pins(1'b1, 1'b0);
    wait_out(32'h140);
    $display("test hold finished");
  endtask
  task automatic t_clear;
    @(posedge clk);
    ctl <= 8'hc4;
    watch(6);
    `CHK("clear staged", 32'h140, mn)
    send(8'hc4);
    cyc(4);
    watch(20);
    `CHK("clear held", 32'h4, mx)
    send(8'h84);
    wait_out(32'h140);
    send(8'ha4);
    watch(8);
    `CHK("autoclear", 32'h4, mn)
    wait_out(32'h140);
    send(8'h84);
    $display("test clear finished");
  endtask
  task automatic t_nodwell;
    send(8'h8c);
    pins(1'b0, 1'b0);
    cyc(6);
    pins(1'b1, 1'b0);
    watch(60);
    `CHK("low sweep depth", 1'b1, mn <= 32'h20)
    `CHK("low jump", 32'h140, out)
    // parked after the jump: a falling edge must start a fresh sweep from idle
    pins(1'b0, 1'b0);
    watch(40);
    `CHK("low restart depth", 1'b1, mn <= 32'h20)
    `CHK("low restart jump", 32'h140, out)
    send(8'h84);
    wait_out(32'h4);
    send(8'h94);
    pins(1'b1, 1'b0);
    cyc(6);
    pins(1'b0, 1'b0);
    watch(60);
    `CHK("high sweep top", 1'b1, mx >= 32'h124)
    `CHK("high jump", 32'h4, out)
    // parked after the jump: a rising edge must start a fresh sweep from idle
    pins(1'b1, 1'b0);
    watch(40);
    `CHK("high restart top", 1'b1, mx >= 32'h124)
    `CHK("high restart jump", 32'h4, out)
    $display("test nodwell finished");
  endtask
  task automatic t_cont;
    pins(1'b1, 1'b0);
    send(8'h9c);
    watch(150);
    `CHK("cont low", 32'h4, mn)
    `CHK("cont high", 32'h140, mx)
    `CHK("done pulses", 1'b1, edges >= 2)
    pins(1'b1, 1'b1);
    cyc(4);
    for (int d = 0; d < 4; d++) begin
      send({6'h27, d[1:0]});
      cyc(3);
      @(negedge clk);
      `CHK("dest", d[1:0], dsel)
      if (d == 0) `CHK("freq", out, freq)
      else if (d == 1) `CHK("phase", out[15:0], phase)
      else `CHK("amp", out[11:0], amp)
    end
    $display("test cont finished");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // tests take about 650 cycles; 6000 cycles, over nine times that, means a hang
  initial begin
    #60000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    cyc(5);
    nrst <= 1'b1;
    t_dwell;
    t_hold;
    t_clear;
    t_nodwell;
    t_cont;
    report_and_stop;
  end
endmodule
`default_nettype wire
